// ---- panel_keys_model.sv ----
// Purpose: front panel keys and input source facing the meter core
// Assumes: keys are active high levels, tick_cyc clocks make one ms
// Notes: input line shows a moving pattern while not sampled
`default_nettype none

module panel_keys_model #(
   parameter int unsigned tick_cyc = 4
) (
   input wire logic pclk,
   input wire logic sample_req,
   output logic key_level,
   output logic key_shift,
   output logic key_up,
   output logic key_zero,
   output logic signed [15:0] sample_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [15:0] value_q = 16'h0000;
   logic [15:0] junk_q = 16'h5a5a;
   initial {key_level, key_shift, key_up, key_zero} = 4'h0;
   always @(posedge pclk) junk_q <= junk_q + 16'h1357;
   assign sample_data = sample_req ? value_q : junk_q;
   // operator holds {level, shift, up, zero} for ms plus margin
   task automatic hold(input logic [3:0] keys, input int ms);
      @(posedge pclk);
      {key_level, key_shift, key_up, key_zero} <= keys;
      repeat (ms * tick_cyc + 8) @(posedge pclk);
      {key_level, key_shift, key_up, key_zero} <= 4'h0;
      repeat (4) @(posedge pclk);
   endtask : hold
endmodule : panel_keys_model

`default_nettype wire

// ---- panel_meter_core.sv ----
// Purpose: sampling, scaling, clamp, forced zero and front panel key timers
// Assumes: keys and sample data synchronous to pclk; sample_data valid while sample_req
// Notes: shift, up and zero presses act on rising edges, a short level press on release; all ms timers scale with tick_cyc
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`default_nettype none

module panel_meter_core
   import panel_meter_pkg::*;
#(
   parameter int unsigned tick_cyc = MS_TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic key_level,
   input wire logic key_shift,
   input wire logic key_up,
   input wire logic key_zero,
   input wire logic signed [15:0] sample_data,
   input wire logic nv_load,
   input wire logic nv_active_in,
   input wire logic signed [31:0] nv_offset_in,
   output logic sample_req,
   output logic signed [31:0] pv_out,
   output logic pv_update,
   output logic cmp_out,
   output logic [1:0] level_ind,
   output logic current_view,
   output logic edit_blink,
   output logic nv_write,
   output logic nv_zero_active,
   output logic signed [31:0] nv_zero_offset
);

   typedef struct packed {
      lvl_t lvl;
      ed_t ed;
      logic [2:0] pidx;
      logic signed [15:0] edit_val;
      logic [31:0] ms_cnt;
      logic [9:0] sec_ms;
      logic [9:0] samp_ms;
      logic [6:0] idle_sec;
      logic [15:0] hold_lvl, hold_pair, hold_zero;
      logic lvl_used, zero_used;
      logic [3:0] keys_prev;
      logic temp_mode, clamp_en;
      logic [1:0] sensor;
      logic [6:0] idle_s;
      logic [4:0] prot_s;
      logic [6:0] clamp_thr;
      logic signed [15:0] src_lo, src_hi, shown_lo, shown_hi, corr, password;
      val_t cmp_set, rel, pv, fz_off;
      logic fz_active, cmp, pv_upd, samp_req, nv_wr;
      logic commit, idle_fire, fz_set_p, fz_clr_p;
   } st_t;

   st_t s;
   st_t n;
   logic ms_tick, sec_tick, lvl_alone, pair, fire_1s, fire_3s, fire_prot, fire_zero;
   logic short_rel, editing, new_clamp, wr_en;
   logic [3:0] keys, press;
   logic [15:0] prot_ms;
   logic signed [15:0] cval;
   val_t raw, rel_new, thr_v;
   logic [9:0] samp_period;

   // clamp a signed edit value into 0..max
   function automatic logic [15:0] lim(input logic signed [15:0] v, input logic [15:0] mx);
      if (v < 16'sh0000) begin
         lim = 16'h0000;
      end else if (v > $signed(mx)) begin
         lim = mx;
      end else begin
         lim = v;
      end
   endfunction : lim

   function automatic logic signed [15:0] stored(input st_t c);
      unique case (c.pidx)
         P_IDLE: stored = {9'h000, c.idle_s};
         P_PROT: stored = {11'h000, c.prot_s};
         P_CLAMP_EN: stored = {15'h0000, c.clamp_en};
         P_CLAMP_THR: stored = {9'h000, c.clamp_thr};
         default: stored = c.password;
      endcase
   endfunction : stored

   function automatic val_t scale(input st_t c, input logic signed [15:0] x);
      logic signed [47:0] num;
      logic signed [47:0] den;
      den = 48'(c.src_hi) - 48'(c.src_lo);
      num = (48'(x) - 48'(c.src_lo)) * (48'(c.shown_hi) - 48'(c.shown_lo));
      if (den == 48'sh0) begin
         scale = 32'(c.shown_lo);
      end else begin
         scale = 32'(num / den + 48'(c.shown_lo));
      end
   endfunction : scale

   function automatic logic reg_ok(input logic [7:0] a);
      reg_ok = (a[1:0] == 2'h0) && (a <= REG_OFFSET);
   endfunction : reg_ok

   always_comb begin
      n = s;
      n.samp_req = 1'b0;
      n.pv_upd = 1'b0;
      n.nv_wr = 1'b0;
      n.commit = 1'b0;
      n.idle_fire = 1'b0;
      n.fz_set_p = 1'b0;
      n.fz_clr_p = 1'b0;
      raw = '0;
      rel_new = '0;
      cval = s.edit_val;
      new_clamp = s.clamp_en;
      thr_v = val_t'({25'h0000000, s.clamp_thr});
      // millisecond and second ticks
      ms_tick = (s.ms_cnt == 32'(tick_cyc - 1));
      n.ms_cnt = ms_tick ? 32'h0 : s.ms_cnt + 32'h1;
      sec_tick = ms_tick && (s.sec_ms == 10'(SEC_MS - 16'h1));
      if (ms_tick) begin
         n.sec_ms = sec_tick ? 10'h000 : s.sec_ms + 10'h001;
      end
      // sample tick
      samp_period = s.temp_mode ? SAMPLE_TEMP_MS : SAMPLE_PROC_MS;
      if (ms_tick) begin
         if (s.samp_ms >= samp_period - 10'h001) begin
            n.samp_ms = 10'h000;
            n.samp_req = 1'b1;
         end else begin
            n.samp_ms = s.samp_ms + 10'h001;
         end
      end
      if (s.samp_req) begin
         raw = s.temp_mode ? 32'(sample_data >>> s.sensor) + 32'(s.corr)
                           : scale(s, sample_data);
         rel_new = raw - s.fz_off;
         n.rel = rel_new;
         n.pv = (!s.temp_mode && s.clamp_en && rel_new < thr_v) ? '0 : rel_new;
         n.cmp = n.pv >= s.cmp_set;
         n.pv_upd = 1'b1;
      end
      // key edges and hold timers
      keys = {key_zero, key_up, key_shift, key_level};
      press = keys & ~s.keys_prev;
      n.keys_prev = keys;
      lvl_alone = key_level && !key_up;
      pair = key_level && key_up;
      prot_ms = 16'((s.prot_s == 5'h00) ? 5'h01 : s.prot_s) * SEC_MS;
      n.hold_lvl = !lvl_alone ? 16'h0 :
                   (ms_tick && s.hold_lvl != 16'hffff) ? s.hold_lvl + 16'h1 : s.hold_lvl;
      n.hold_pair = !pair ? 16'h0 :
                    (ms_tick && s.hold_pair != 16'hffff) ? s.hold_pair + 16'h1 : s.hold_pair;
      n.hold_zero = !key_zero ? 16'h0 :
                    (ms_tick && s.hold_zero != 16'hffff) ? s.hold_zero + 16'h1 : s.hold_zero;
      fire_1s = lvl_alone && ms_tick && !s.lvl_used && s.hold_lvl == SEC_MS - 16'h1;
      fire_3s = lvl_alone && ms_tick && !s.lvl_used && s.hold_lvl == LVL_UP_MS - 16'h1;
      fire_prot = pair && ms_tick && s.hold_pair == prot_ms - 16'h1;
      fire_zero = key_zero && ms_tick && !s.zero_used && s.hold_zero == SEC_MS - 16'h1;
      short_rel = !key_level && s.keys_prev[0] && !s.lvl_used;
      editing = (s.ed == ED_SHOW) || (s.ed == ED_CHANGE);
      if (!key_level) begin
         n.lvl_used = 1'b0;
      end else if (pair) begin
         n.lvl_used = 1'b1;
      end
      if (!key_zero) begin
         n.zero_used = 1'b0;
      end
      // idle return counter
      if (|press) begin
         n.idle_sec = 7'h00;
         n.sec_ms = 10'h000;
      end else if (sec_tick && s.idle_sec != 7'h7f) begin
         n.idle_sec = s.idle_sec + 7'h01;
      end
      // level and edit sequencing
      if (s.idle_s != 7'h00 && sec_tick && !(|press)
          && 7'(s.idle_sec + 7'h01) == s.idle_s) begin
         n.idle_fire = 1'b1;
         n.commit = editing;
         n.lvl = LV_OPER;
         n.ed = ED_VIEW;
      end else if (s.lvl == LV_OPER && fire_3s) begin
         n.lvl = LV_INIT;
         n.ed = ED_NAME;
         n.pidx = P_PASS;
         n.lvl_used = 1'b1;
      end else if (s.lvl == LV_OPER && fire_prot) begin
         n.lvl = LV_PROT;
      end else if (s.lvl != LV_OPER && fire_1s) begin
         n.lvl = (s.lvl == LV_ADV) ? LV_INIT : LV_OPER;
         n.ed = (s.lvl == LV_ADV) ? ED_NAME : ED_VIEW;
         n.pidx = P_PASS;
         n.lvl_used = 1'b1;
      end else if (short_rel && (s.lvl == LV_INIT || s.lvl == LV_ADV)) begin
         n.commit = editing;
         n.ed = ED_NAME;
         if (editing && s.pidx == P_CLAMP_EN) begin
            new_clamp = s.edit_val[0];
         end
         if (s.lvl == LV_INIT) begin
            if (editing && s.edit_val == ADV_PASSWORD) begin
               n.lvl = LV_ADV;
               n.pidx = P_IDLE;
            end
         end else if (s.pidx == P_CLAMP_EN) begin
            n.pidx = new_clamp ? P_CLAMP_THR : P_IDLE;
         end else begin
            n.pidx = (s.pidx >= P_CLAMP_THR) ? P_IDLE : s.pidx + 3'h1;
         end
      end else if (s.ed != ED_VIEW && press[1]) begin
         if (s.ed == ED_NAME) begin
            n.ed = ED_SHOW;
            n.edit_val = stored(s);
         end else if (s.ed == ED_SHOW) begin
            n.ed = ED_CHANGE;
         end else begin
            n.edit_val = s.edit_val - 16'sh0001;
         end
      end else if (s.ed == ED_CHANGE && press[2]) begin
         n.edit_val = s.edit_val + 16'sh0001;
      end
      // commit of the value on show
      if (n.commit) begin
         unique case (s.pidx)
            P_IDLE: n.idle_s = 7'(lim(cval, 16'(IDLE_MAX)));
            P_PROT: n.prot_s = 5'(lim(cval, 16'(PROT_MAX)));
            P_CLAMP_EN: n.clamp_en = cval[0];
            P_CLAMP_THR: n.clamp_thr = 7'(lim(cval, 16'(THR_MAX)));
            default: n.password = cval;
         endcase
      end
      // forced zero: nv_load restore at any time, set and cancel by key only while the current value is on show
      if (nv_load) begin
         n.fz_active = nv_active_in;
         n.fz_off = nv_offset_in;
      end else if (s.lvl == LV_OPER && s.ed == ED_VIEW && fire_zero) begin
         n.fz_active = 1'b0;
         n.fz_off = '0;
         n.fz_clr_p = 1'b1;
         n.nv_wr = 1'b1;
         n.zero_used = 1'b1;
      end else if (s.lvl == LV_OPER && s.ed == ED_VIEW && press[3]) begin
         n.fz_active = 1'b1;
         n.fz_off = s.fz_off + s.rel;
         n.rel = '0;
         n.fz_set_p = 1'b1;
         n.nv_wr = 1'b1;
      end
      // APB writes
      wr_en = psel && penable && pwrite && reg_ok(paddr);
      if (wr_en) begin
         unique case (paddr)
            REG_CTRL: begin
               n.temp_mode = pwdata[CTRL_TEMP_BIT];
               n.clamp_en = pwdata[CTRL_CLAMP_BIT];
               n.sensor = pwdata[CTRL_SENSOR_LSB +: 2];
            end
            REG_IDLE: n.idle_s = 7'(lim(pwdata[15:0], 16'(IDLE_MAX)));
            REG_PROT: n.prot_s = 5'(lim(pwdata[15:0], 16'(PROT_MAX)));
            REG_CLAMP: n.clamp_thr = 7'(lim(pwdata[15:0], 16'(THR_MAX)));
            REG_SRC_LO: n.src_lo = pwdata[15:0];
            REG_SRC_HI: n.src_hi = pwdata[15:0];
            REG_SHOWN_LO: n.shown_lo = pwdata[15:0];
            REG_SHOWN_HI: n.shown_hi = pwdata[15:0];
            REG_CORR: n.corr = pwdata[15:0];
            REG_CMP: n.cmp_set = pwdata;
            REG_PASS: n.password = pwdata[15:0];
            default: n.password = s.password;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.prot_s <= PROT_RST;
      end else begin
         s <= n;
      end
   end

   // register read path
   always_comb begin
      prdata = 32'h0;
      if (psel && !pwrite) begin
         unique case (paddr)
            REG_CTRL: prdata = {28'h0, s.sensor, s.clamp_en, s.temp_mode};
            REG_IDLE: prdata = {25'h0, s.idle_s};
            REG_PROT: prdata = {27'h0, s.prot_s};
            REG_CLAMP: prdata = {25'h0, s.clamp_thr};
            REG_SRC_LO: prdata = 32'(s.src_lo);
            REG_SRC_HI: prdata = 32'(s.src_hi);
            REG_SHOWN_LO: prdata = 32'(s.shown_lo);
            REG_SHOWN_HI: prdata = 32'(s.shown_hi);
            REG_CORR: prdata = 32'(s.corr);
            REG_CMP: prdata = s.cmp_set;
            REG_PASS: prdata = 32'(s.password);
            REG_STATUS: prdata = {26'h0, s.cmp, s.fz_active, s.ed, s.lvl};
            REG_PV: prdata = s.pv;
            REG_OFFSET: prdata = s.fz_off;
            default: prdata = 32'h0;
         endcase
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_ok(paddr);
   assign sample_req = s.samp_req;
   assign pv_out = s.pv;
   assign pv_update = s.pv_upd;
   assign cmp_out = s.cmp;
   assign level_ind = s.lvl;
   assign current_view = (s.lvl == LV_OPER) && (s.ed == ED_VIEW);
   assign edit_blink = (s.ed == ED_CHANGE);
   assign nv_write = s.nv_wr;
   assign nv_zero_active = s.fz_active;
   assign nv_zero_offset = s.fz_off;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_sample;
      s.samp_req ##1 s.pv_upd;
   endsequence

   a_sample_update: assert property (s.samp_req |-> seq_sample)
      else $error("process value not updated after sample");
   a_cmp_follows: assert property (s.pv_upd |-> s.cmp == (s.pv >= s.cmp_set))
      else $error("comparison output not derived from value");
   a_clamp_zero: assert property (s.pv_upd && !s.temp_mode && s.clamp_en |->
      (s.pv == 0 || s.pv >= thr_v))
      else $error("value below clamp threshold shown");
   a_idle_off: assert property ($past(s.idle_s) == 7'h00 |-> !s.idle_fire)
      else $error("idle return fired while disabled");
   a_idle_return: assert property (s.idle_fire |-> s.lvl == LV_OPER && s.ed == ED_VIEW)
      else $error("idle return did not reach current view");
   a_idle_commit: assert property (s.idle_fire && $past(editing) |-> s.commit)
      else $error("idle return lost edited value");
   a_prot_range: assert property (s.prot_s <= PROT_MAX && s.idle_s <= IDLE_MAX)
      else $error("hold or idle setting out of range");
   a_protect_entry: assert property (s.lvl == LV_PROT && $past(s.lvl) == LV_OPER |->
      $past(s.hold_pair) == $past(prot_ms) - 16'h1)
      else $error("protect level entered without full hold");
   a_adv_password: assert property (s.lvl == LV_ADV && $past(s.lvl) == LV_INIT |->
      $past(s.edit_val) == ADV_PASSWORD)
      else $error("advanced level entered without password");
   a_fz_rezero: assert property (s.fz_set_p |-> s.fz_active &&
      s.fz_off == $past(s.fz_off) + $past(s.rel))
      else $error("forced zero offset not accumulated");
   a_fz_cancel: assert property (s.fz_clr_p |-> !s.fz_active && s.fz_off == 0)
      else $error("forced zero not cancelled");
   a_nv_store: assert property ((s.fz_set_p || s.fz_clr_p) |-> s.nv_wr ##1 !s.nv_wr)
      else $error("forced zero state not stored");

endmodule : panel_meter_core

`default_nettype wire

// ---- panel_meter_pkg.sv ----
// Purpose: shared constants and types of the panel meter measure and key timer block
// Assumes: 40 MHz pclk, APB register access with 32-bit data
// Notes: all timing figures are kept in their own unit and turned into counts
`default_nettype none

package panel_meter_pkg;

   // clock and timing
   localparam int unsigned CLK_MHZ = 32'h28;                     // 40 MHz
   localparam int unsigned MS_TICK_US = 32'h3e8;                 // 1000 us
   localparam int unsigned MS_TICK_CYC = MS_TICK_US * CLK_MHZ;   // cycles per ms
   localparam logic [9:0] SAMPLE_PROC_MS = 10'h0fa;              // 250 ms
   localparam logic [9:0] SAMPLE_TEMP_MS = 10'h1f4;              // 500 ms
   localparam logic [15:0] SEC_MS = 16'h03e8;                    // 1 s
   localparam logic [15:0] LVL_UP_MS = 16'h0bb8;                 // 3 s

   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_IDLE = 8'h04;
   localparam logic [7:0] REG_PROT = 8'h08;
   localparam logic [7:0] REG_CLAMP = 8'h0c;
   localparam logic [7:0] REG_SRC_LO = 8'h10;
   localparam logic [7:0] REG_SRC_HI = 8'h14;
   localparam logic [7:0] REG_SHOWN_LO = 8'h18;
   localparam logic [7:0] REG_SHOWN_HI = 8'h1c;
   localparam logic [7:0] REG_CORR = 8'h20;
   localparam logic [7:0] REG_CMP = 8'h24;
   localparam logic [7:0] REG_PASS = 8'h28;
   localparam logic [7:0] REG_STATUS = 8'h2c;
   localparam logic [7:0] REG_PV = 8'h30;
   localparam logic [7:0] REG_OFFSET = 8'h34;

   // control field positions
   localparam int unsigned CTRL_TEMP_BIT = 32'h0;
   localparam int unsigned CTRL_CLAMP_BIT = 32'h1;
   localparam int unsigned CTRL_SENSOR_LSB = 32'h2;

   // limits and reset values
   localparam logic [6:0] IDLE_MAX = 7'h63;
   localparam logic [4:0] PROT_MAX = 5'h13;
   localparam logic [6:0] THR_MAX = 7'h63;
   localparam logic [4:0] PROT_RST = 5'h05;
   localparam logic signed [15:0] ADV_PASSWORD = 16'hff57;       // -169

   // editable parameter indices
   localparam logic [2:0] P_IDLE = 3'h0;
   localparam logic [2:0] P_PROT = 3'h1;
   localparam logic [2:0] P_CLAMP_EN = 3'h2;
   localparam logic [2:0] P_CLAMP_THR = 3'h3;
   localparam logic [2:0] P_PASS = 3'h4;

   typedef enum logic [1:0] {LV_OPER, LV_INIT, LV_ADV, LV_PROT} lvl_t;
   typedef enum logic [1:0] {ED_VIEW, ED_NAME, ED_SHOW, ED_CHANGE} ed_t;
   typedef logic signed [31:0] val_t;

endpackage : panel_meter_pkg

`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for the panel meter core
// Assumes: TK clocks per ms tick, APB answers with pready
// Notes: keys and input samples come from panel_keys_model
`default_nettype none

module testbench
   import panel_meter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   localparam int SEC = 1000 * TK;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, key_level, key_shift, key_up, key_zero;
   logic signed [15:0] sample_data;
   logic nv_load = 1'b0;
   logic nv_active_in = 1'b0;
   logic signed [31:0] nv_offset_in = 32'h0;
   logic sample_req, pv_update, cmp_out, current_view, edit_blink, nv_write, nv_zero_active;
   logic signed [31:0] pv_out, nv_zero_offset;
   logic [1:0] level_ind;
   logic [31:0] rdat, rerr;
   logic [31:0] since = 32'h0;
   logic [31:0] last_gap = 32'h0;
   int fail_count = 0;
   int checked = 0;
   int nvw = 0;

   always #12.5 pclk = ~pclk;

   panel_meter_core #(.tick_cyc(TK)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_level(key_level), .key_shift(key_shift), .key_up(key_up), .key_zero(key_zero),
      .sample_data(sample_data), .nv_load(nv_load), .nv_active_in(nv_active_in),
      .nv_offset_in(nv_offset_in), .sample_req(sample_req), .pv_out(pv_out),
      .pv_update(pv_update), .cmp_out(cmp_out), .level_ind(level_ind),
      .current_view(current_view), .edit_blink(edit_blink), .nv_write(nv_write),
      .nv_zero_active(nv_zero_active), .nv_zero_offset(nv_zero_offset));

   panel_keys_model #(.tick_cyc(TK)) panel (
      .pclk(pclk), .sample_req(sample_req), .key_level(key_level), .key_shift(key_shift),
      .key_up(key_up), .key_zero(key_zero), .sample_data(sample_data));

   // store writes and sample spacing
   always @(posedge pclk) begin
      if (nv_write === 1'b1) nvw <= nvw + 1;
      since <= (sample_req === 1'b1) ? 32'h1 : since + 32'h1;
      if (sample_req === 1'b1) last_gap <= since;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) fail_count++;
      rdat = prdata;
      rerr = {31'h0, pslverr};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0);
      chk(rdat, want);
   endtask : rc

   // input value for the next sample, then check the update
   task automatic next_pv(input logic signed [15:0] s, input logic [31:0] want, input logic c);
      int n;
      n = 0;
      panel.value_q <= s;
      do begin
         @(posedge pclk);
         n++;
      end while (sample_req !== 1'b1 && n < 3000 * TK);
      @(posedge pclk);
      chk({31'h0, pv_update}, 32'h1);
      chk(pv_out, want);
      chk({31'h0, cmp_out}, {31'h0, c});
   endtask : next_pv

   task automatic nv(input logic a, input logic [31:0] off);
      nv_active_in <= a;
      nv_offset_in <= off;
      nv_load <= 1'b1;
      @(posedge pclk);
      nv_load <= 1'b0;
      @(posedge pclk);
   endtask : nv

   task automatic tally_and_finish();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // whole run is near 64k clocks, cut at 90k
   initial begin
      #2250000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      int n;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(REG_PROT, 32'h5);
      wr(REG_PROT, 32'h19);
      rc(REG_PROT, 32'h13);
      wr(REG_IDLE, 32'h96);
      rc(REG_IDLE, 32'h63);
      wr(REG_IDLE, 32'h0);
      rc(REG_IDLE, 32'h0);
      wr(REG_CLAMP, 32'hc8);
      rc(REG_CLAMP, 32'h63);
      bus(1'b0, 8'h38, 32'h0);
      chk(rerr, 32'h1);
      $display("register test done");
      wr(REG_SRC_LO, 32'h0);
      wr(REG_SRC_HI, 32'h64);
      wr(REG_SHOWN_LO, 32'h3e8);
      wr(REG_SHOWN_HI, 32'h0);
      wr(REG_CMP, 32'h2bc);
      wr(REG_CTRL, 32'h0);
      next_pv(16'h0019, 32'h2ee, 1'b1);
      next_pv(16'h0028, 32'h258, 1'b0);
      chk(last_gap, 32'h3e8);
      wr(REG_CLAMP, 32'h63);
      wr(REG_CTRL, 32'h2);
      next_pv(16'h005f, 32'h0, 1'b0);
      next_pv(16'h0000, 32'h3e8, 1'b1);
      wr(REG_CTRL, 32'h0);
      $display("scaling test done");
      next_pv(16'h0019, 32'h2ee, 1'b1);
      chk({31'h0, current_view}, 32'h1);
      panel.hold(4'h1, 0);
      chk({31'h0, nv_zero_active}, 32'h1);
      chk(32'(nvw), 32'h1);
      next_pv(16'h0014, 32'h32, 1'b0);
      panel.hold(4'h1, 0);
      rc(REG_OFFSET, 32'h320);
      chk(nv_zero_offset, 32'h320);
      next_pv(16'h001e, 32'hffffff9c, 1'b0);
      wr(REG_CTRL, 32'h2);
      next_pv(16'h001e, 32'h0, 1'b0);
      wr(REG_CTRL, 32'h0);
      panel.hold(4'h1, 1000);
      chk({31'h0, nv_zero_active}, 32'h0);
      chk(32'(nvw > 2), 32'h1);
      next_pv(16'h001e, 32'h2bc, 1'b1);
      nv(1'b1, 32'h64);
      next_pv(16'h001e, 32'h258, 1'b0);
      nv(1'b0, 32'h0);
      $display("forced zero test done");
      wr(REG_CORR, 32'h7);
      wr(REG_CTRL, 32'h5);
      next_pv(16'h00c8, 32'h6b, 1'b0);
      next_pv(16'hffd8, 32'hfffffff3, 1'b0);
      chk(last_gap, 32'h7d0);
      wr(REG_CTRL, 32'h0);
      $display("temperature test done");
      wr(REG_PROT, 32'h0);
      panel.hold(4'ha, 500);
      chk({30'h0, level_ind}, 32'h0);
      panel.hold(4'ha, 1000);
      chk({30'h0, level_ind}, 32'h3);
      panel.hold(4'h8, 1000);
      panel.hold(4'h8, 3000);
      chk({30'h0, level_ind}, 32'h1);
      wr(REG_PASS, 32'hffffff58);
      panel.hold(4'h4, 0);
      chk({31'h0, edit_blink}, 32'h0);
      panel.hold(4'h4, 0);
      chk({31'h0, edit_blink}, 32'h1);
      panel.hold(4'h4, 0);
      panel.hold(4'h8, 0);
      chk({30'h0, level_ind}, 32'h2);
      $display("level test done");
      panel.hold(4'h4, 0);
      wr(REG_IDLE, 32'h2);
      panel.hold(4'h4, 0);
      panel.hold(4'h2, 0);
      n = 0;
      while (level_ind !== 2'h0 && n < 3 * SEC) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n > 2 * SEC - 40), 32'h1);
      chk({31'h0, current_view}, 32'h1);
      rc(REG_IDLE, 32'h1);
      wr(REG_IDLE, 32'h0);
      panel.hold(4'h8, 3000);
      wr(REG_PASS, 32'hffffff56);
      panel.hold(4'h4, 0);
      panel.hold(4'h8, 0);
      chk({30'h0, level_ind}, 32'h1);
      panel.hold(4'h8, 1000);
      chk({30'h0, level_ind}, 32'h0);
      $display("idle and password test done");
      tally_and_finish();
   end
endmodule : testbench

`default_nettype wire
